// ---- logic/system_clock_mode_control.sv ----
// System clock source selection, oscillator control and halt mode decode.
//
// Local design decisions: the register offsets and register access over APB.
module system_clock_mode_control #(
    parameter int IRC_EDGES = clock_mode_pkg::IRC_STABLE_EDGES,
    parameter int HXT_EDGES = clock_mode_pkg::HXT_STABLE_EDGES,
    parameter int LXT_EDGES = clock_mode_pkg::LXT_STABLE_EDGES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        internal_fast_rc_osc,
    input  wire logic        fast_crystal_osc,
    input  wire logic        internal_slow_rc_osc,
    input  wire logic        slow_crystal_osc,
    input  wire logic        crystal_pin_in_func,
    input  wire logic        crystal_pin_out_func,
    input  wire logic        cpu_halt,
    output logic             internal_fast_rc_run,
    output logic             fast_crystal_run,
    output logic             internal_slow_rc_run,
    output logic             slow_crystal_run,
    output logic             fast_crystal_drive_range,
    output logic             slow_crystal_speedup,
    output logic             sys_tick,
    output logic             switch_busy,
    output logic [2:0]       halt_mode
);
    //--------------------------------------------------------------------
    // Parameter checks
    //--------------------------------------------------------------------
    if (IRC_EDGES < 1 || HXT_EDGES < 1 || LXT_EDGES < 1 ||
        IRC_EDGES > 65535 || HXT_EDGES > 65535 || LXT_EDGES > 65535)
    begin : g_bad_edges
        $error("Stable edge counts must lie between 1 and 65535.");
    end

    //--------------------------------------------------------------------
    // Helper functions
    //--------------------------------------------------------------------
    // Edge of the source named by a select setting; index 0 fast RC, 1 fast
    // crystal, 2 slow RC, 3 slow crystal.
    function automatic logic src_edge(input logic [2:0] code, input logic fast_source_pick,
                                      input logic slow_source_pick, input logic [3:0] e);
        logic r;
        if (code == clock_mode_pkg::CODE_SLOW)
            r = slow_source_pick ? e[3] : e[2];
        else
            r = fast_source_pick ? e[1] : e[0];
        return r;
    endfunction

    function automatic logic [5:0] div_mask(input logic [2:0] code);
        logic [6:0] m;
        m = (7'h01 << code) - 7'h01;
        return m[5:0];
    endfunction

    //--------------------------------------------------------------------
    // Oscillator sampling
    //--------------------------------------------------------------------
    // The oscillators are far slower than pclk, so their edges are found by
    // sampling; an edge counts once the second and third stages agree.
    logic [3:0] osc_s1_q;
    logic [3:0] osc_s2_q;
    logic [3:0] osc_s3_q;
    logic [3:0] osc_lvl_q;
    wire  [3:0] osc_raw = {slow_crystal_osc, internal_slow_rc_osc,
                           fast_crystal_osc, internal_fast_rc_osc};
    wire  [3:0] osc_agree = ~(osc_s2_q ^ osc_s3_q);
    wire  [3:0] osc_edge  = osc_agree & osc_s3_q & ~osc_lvl_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_s1_q  <= 4'h0;
            osc_s2_q  <= 4'h0;
            osc_s3_q  <= 4'h0;
            osc_lvl_q <= 4'h0;
        end
        else
        begin
            osc_s1_q  <= osc_raw;
            osc_s2_q  <= osc_s1_q;
            osc_s3_q  <= osc_s2_q;
            osc_lvl_q <= (osc_agree & osc_s3_q) | (~osc_agree & osc_lvl_q);
        end
    end

    //--------------------------------------------------------------------
    // Register bus decode
    //--------------------------------------------------------------------
    logic [7:0] sys_sel_q;
    logic       irc_on_q;
    logic       hxt_on_q;
    logic       hxt_range_q;
    logic       lxt_on_q;
    logic       lxt_speed_q;
    logic [2:0] cur_code_q;
    logic       cur_fhs_q;
    logic       cur_fss_q;
    logic [2:0] stable;

    wire hit_sys = (paddr == clock_mode_pkg::ADDR_SYS_SEL);
    wire hit_irc = (paddr == clock_mode_pkg::ADDR_IRC);
    wire hit_hxt = (paddr == clock_mode_pkg::ADDR_HXT);
    wire hit_lxt = (paddr == clock_mode_pkg::ADDR_LXT);
    wire hit     = hit_sys | hit_irc | hit_hxt | hit_lxt;
    wire access  = psel & penable;
    wire wr      = access & pwrite & hit;
    wire [7:0] wd = pwdata[7:0];

    // Drive range is frozen while the crystal owns both pins and runs.
    wire range_lock = crystal_pin_in_func & crystal_pin_out_func & hxt_on_q;
    // Speed-up is frozen while the system runs on the slow crystal.
    wire speed_lock = (cur_code_q == clock_mode_pkg::CODE_SLOW) & cur_fss_q;

    wire irc_set = wr & hit_irc & wd[clock_mode_pkg::ON_BIT] & ~irc_on_q;
    wire hxt_set = wr & hit_hxt & wd[clock_mode_pkg::ON_BIT] & ~hxt_on_q;
    wire lxt_set = wr & hit_lxt & wd[clock_mode_pkg::ON_BIT] & ~lxt_on_q;

    wire [7:0] rd_sys = sys_sel_q & clock_mode_pkg::SYS_SEL_WMASK;
    wire [7:0] rd_irc = {6'h00, stable[0], irc_on_q};
    wire [7:0] rd_hxt = {5'h00, hxt_range_q, stable[1], hxt_on_q};
    wire [7:0] rd_lxt = {5'h00, lxt_speed_q, stable[2], lxt_on_q};
    wire [7:0] rd_sel = hit_sys ? rd_sys :
                        hit_irc ? rd_irc :
                        hit_hxt ? rd_hxt :
                        hit_lxt ? rd_lxt : 8'h00;

    assign pready  = access;
    assign pslverr = access & ~hit;

    // Read data is captured in the setup cycle so the access phase needs no wait.
    logic [7:0] rdata_q;
    assign prdata = {24'h000000, rdata_q};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_q <= 8'h00;
        else if (psel && !penable)
            rdata_q <= pwrite ? 8'h00 : rd_sel;
    end

    //--------------------------------------------------------------------
    // Control registers
    //--------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_sel_q   <= clock_mode_pkg::SYS_SEL_RST;
            irc_on_q    <= clock_mode_pkg::IRC_ON_RST;
            hxt_on_q    <= clock_mode_pkg::HXT_ON_RST;
            hxt_range_q <= clock_mode_pkg::OPT_RST;
            lxt_on_q    <= clock_mode_pkg::LXT_ON_RST;
            lxt_speed_q <= clock_mode_pkg::OPT_RST;
        end
        else if (wr)
        begin
            if (hit_sys)
                sys_sel_q <= wd & clock_mode_pkg::SYS_SEL_WMASK;
            if (hit_irc)
                irc_on_q <= wd[clock_mode_pkg::ON_BIT];
            if (hit_hxt)
                hxt_on_q <= wd[clock_mode_pkg::ON_BIT];
            if (hit_hxt && !range_lock)
                hxt_range_q <= wd[clock_mode_pkg::OPT_BIT];
            if (hit_lxt)
                lxt_on_q <= wd[clock_mode_pkg::ON_BIT];
            if (hit_lxt && !speed_lock)
                lxt_speed_q <= wd[clock_mode_pkg::OPT_BIT];
        end
    end

    //--------------------------------------------------------------------
    // Stable flags
    //--------------------------------------------------------------------
    // A flag is a count of oscillator edges since enable; it cannot be written.
    logic [15:0] stab_cnt_q [3];
    wire  [15:0] stab_lim [3];
    wire  [2:0]  stab_on   = {lxt_on_q, hxt_on_q, irc_on_q};
    wire  [2:0]  stab_set  = {lxt_set, hxt_set, irc_set};
    wire  [2:0]  stab_edge = {osc_edge[3], osc_edge[1], osc_edge[0]};

    assign stab_lim[0] = 16'(IRC_EDGES);
    assign stab_lim[1] = 16'(HXT_EDGES);
    assign stab_lim[2] = 16'(LXT_EDGES);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 3; i++)
                stab_cnt_q[i] <= 16'h0000;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (!stab_on[i] || stab_set[i])
                    stab_cnt_q[i] <= 16'h0000;
                else if (stab_edge[i] && stab_cnt_q[i] != stab_lim[i])
                    stab_cnt_q[i] <= stab_cnt_q[i] + 16'h0001;
            end
        end
    end

    for (genvar g = 0; g < 3; g++)
    begin : g_stable
        assign stable[g] = stab_on[g] && (stab_cnt_q[g] == stab_lim[g]);
    end

    //--------------------------------------------------------------------
    // Clock switching
    //--------------------------------------------------------------------
    clock_mode_pkg::switch_state_t st_q;
    logic [2:0]                    drain_q;
    logic [5:0]                    div_q;

    wire [2:0] tgt_code = sys_sel_q[clock_mode_pkg::CODE_LSB +: 3];
    wire       tgt_fhs  = sys_sel_q[clock_mode_pkg::FHS_BIT];
    wire       tgt_fss  = sys_sel_q[clock_mode_pkg::FSS_BIT];
    wire       f_keep   = sys_sel_q[clock_mode_pkg::FKEEP_BIT];
    wire       s_keep   = sys_sel_q[clock_mode_pkg::SKEEP_BIT];
    wire       cur_slow = (cur_code_q == clock_mode_pkg::CODE_SLOW);
    wire       tgt_slow = (tgt_code == clock_mode_pkg::CODE_SLOW);
    wire       in_wait  = (st_q == clock_mode_pkg::S_WAIT);
    wire       changed  = {tgt_code, tgt_fhs, tgt_fss} !=
                          {cur_code_q, cur_fhs_q, cur_fss_q};

    wire cur_edge = src_edge(cur_code_q, cur_fhs_q, cur_fss_q, osc_edge);
    wire tgt_edge = src_edge(tgt_code, tgt_fhs, tgt_fss, osc_edge);
    // The slow RC has no flag and is taken as always stable.
    wire tgt_ready = !tgt_slow || !tgt_fss || stable[2];

    // Halt stops the ticks only when the running source is stopped with it.
    wire f_gate   = cpu_halt & ~f_keep;
    wire s_gate   = cpu_halt & ~s_keep;
    wire run_gate = cur_slow ? s_gate : f_gate;
    wire div_hit  = cur_slow || ((div_q & div_mask(cur_code_q)) == 6'h00);
    wire tick     = cur_edge & div_hit & ~run_gate & ~in_wait;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q       <= clock_mode_pkg::S_RUN;
            drain_q    <= 3'h0;
            div_q      <= 6'h00;
            cur_code_q <= 3'h0;
            cur_fhs_q  <= 1'b0;
            cur_fss_q  <= 1'b0;
        end
        else
        begin
            if (cur_edge && !cur_slow)
                div_q <= div_q + 6'h01;
            case (st_q)
                clock_mode_pkg::S_RUN:
                begin
                    if (changed)
                    begin
                        st_q    <= clock_mode_pkg::S_DRAIN;
                        drain_q <= 3'h0;
                    end
                end
                clock_mode_pkg::S_DRAIN:
                begin
                    if (tick && drain_q == clock_mode_pkg::DRAIN_LAST)
                        st_q <= clock_mode_pkg::S_WAIT;
                    else if (tick)
                        drain_q <= drain_q + 3'h1;
                end
                clock_mode_pkg::S_WAIT:
                begin
                    if (tgt_edge && tgt_ready)
                    begin
                        st_q       <= clock_mode_pkg::S_RUN;
                        cur_code_q <= tgt_code;
                        cur_fhs_q  <= tgt_fhs;
                        cur_fss_q  <= tgt_fss;
                        div_q      <= 6'h00;
                    end
                end
                default:
                    st_q <= clock_mode_pkg::S_RUN;
            endcase
        end
    end

    //--------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------
    wire [2:0] mode_d = !cpu_halt            ? clock_mode_pkg::M_RUN       :
                        (!f_keep && !s_keep) ? clock_mode_pkg::M_SLEEP     :
                        (!f_keep &&  s_keep) ? clock_mode_pkg::M_IDLE_SLOW :
                        ( f_keep &&  s_keep) ? clock_mode_pkg::M_IDLE_BOTH :
                                               clock_mode_pkg::M_IDLE_FAST;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_tick                 <= 1'b0;
            switch_busy              <= 1'b0;
            halt_mode                <= clock_mode_pkg::M_RUN;
            internal_fast_rc_run     <= clock_mode_pkg::IRC_ON_RST;
            fast_crystal_run         <= 1'b0;
            internal_slow_rc_run     <= 1'b1;
            slow_crystal_run         <= 1'b0;
            fast_crystal_drive_range <= 1'b0;
            slow_crystal_speedup     <= 1'b0;
        end
        else
        begin
            sys_tick                 <= tick;
            switch_busy              <= (st_q != clock_mode_pkg::S_RUN) | changed;
            halt_mode                <= mode_d;
            internal_fast_rc_run     <= irc_on_q & ~f_gate;
            fast_crystal_run         <= hxt_on_q & ~f_gate;
            internal_slow_rc_run     <= ~s_gate;
            slow_crystal_run         <= lxt_on_q & ~s_gate;
            fast_crystal_drive_range <= hxt_range_q;
            slow_crystal_speedup     <= lxt_speed_q;
        end
    end

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    sequence s_write_on(logic [11:0] a);
        psel && penable && pwrite && paddr == a && pwdata[0];
    endsequence

    property p_div_align;
        @(posedge pclk) disable iff (!presetn)
        sys_tick && !$past(cur_slow) |-> ($past(div_q) & $past(div_mask(cur_code_q))) == 6'h00;
    endproperty
    a_div_align: assert property (p_div_align) else $error("Divided tick off phase.");

    property p_drain_four;
        @(posedge pclk) disable iff (!presetn)
        st_q == clock_mode_pkg::S_RUN && changed |=> (st_q == clock_mode_pkg::S_DRAIN)[*4];
    endproperty
    a_drain_four: assert property (p_drain_four) else $error("Switch left drain early.");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && hit_sys |-> prdata[31:8] == 24'h0 && !prdata[4];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set.");

    property p_irc_set_clears;
        @(posedge pclk) disable iff (!presetn)
        s_write_on(clock_mode_pkg::ADDR_IRC) and !irc_on_q |=> !stable[0] [*2];
    endproperty
    a_irc_set_clears: assert property (p_irc_set_clears) else $error("Flag not cleared.");

    property p_range_lock;
        @(posedge pclk) disable iff (!presetn)
        wr && hit_hxt && range_lock |=> $stable(hxt_range_q);
    endproperty
    a_range_lock: assert property (p_range_lock) else $error("Drive range changed.");

    property p_speed_lock;
        @(posedge pclk) disable iff (!presetn)
        wr && hit_lxt && speed_lock |=> $stable(lxt_speed_q);
    endproperty
    a_speed_lock: assert property (p_speed_lock) else $error("Speed-up changed.");

    property p_slow_wait;
        @(posedge pclk) disable iff (!presetn)
        in_wait && tgt_slow && tgt_fss && !stable[2] |=> in_wait;
    endproperty
    a_slow_wait: assert property (p_slow_wait) else $error("Switched to unstable crystal.");

    property p_halt_mode;
        @(posedge pclk) disable iff (!presetn)
        cpu_halt && !f_keep && s_keep |=> halt_mode == clock_mode_pkg::M_IDLE_SLOW;
    endproperty
    a_halt_mode: assert property (p_halt_mode) else $error("Wrong halt mode.");

    property p_no_tick_wait;
        @(posedge pclk) disable iff (!presetn)
        in_wait |=> !sys_tick;
    endproperty
    a_no_tick_wait: assert property (p_no_tick_wait) else $error("Tick during handover.");

    property p_off_clears;
        @(posedge pclk) disable iff (!presetn)
        !hxt_on_q |=> stab_cnt_q[1] == 16'h0000;
    endproperty
    a_off_clears: assert property (p_off_clears) else $error("Flag set while off.");
endmodule

// ---- common/clock_mode_pkg.sv ----
// Constants, field layout and state types of the system clock mode control.
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package clock_mode_pkg;
    localparam logic [11:0] ADDR_SYS_SEL   = 12'h000;
    localparam logic [11:0] ADDR_IRC       = 12'h004;
    localparam logic [11:0] ADDR_HXT       = 12'h008;
    localparam logic [11:0] ADDR_LXT       = 12'h00c;
    localparam int          CODE_LSB       = 5;
    localparam int          FHS_BIT        = 3;
    localparam int          FSS_BIT        = 2;
    localparam int          FKEEP_BIT      = 1;
    localparam int          SKEEP_BIT      = 0;
    localparam int          ON_BIT         = 0;
    localparam int          STABLE_BIT     = 1;
    localparam int          OPT_BIT        = 2;
    localparam logic [7:0]  SYS_SEL_RST    = 8'h00;
    localparam logic        IRC_ON_RST     = 1'b1;
    localparam logic        HXT_ON_RST     = 1'b0;
    localparam logic        LXT_ON_RST     = 1'b0;
    localparam logic        OPT_RST        = 1'b0;
    localparam logic [7:0]  SYS_SEL_WMASK  = 8'hef;
    localparam logic [2:0]  CODE_SLOW      = 3'h7;
    localparam logic [2:0]  DRAIN_LAST     = 3'h3;
    localparam int          IRC_STABLE_EDGES = 64;
    localparam int          HXT_STABLE_EDGES = 1024;
    localparam int          LXT_STABLE_EDGES = 1024;

    typedef enum logic [1:0] {
        S_RUN   = 2'b00,
        S_DRAIN = 2'b01,
        S_WAIT  = 2'b11
    } switch_state_t;

    typedef enum logic [2:0] {
        M_RUN       = 3'h0,
        M_SLEEP     = 3'h1,
        M_IDLE_SLOW = 3'h3,
        M_IDLE_BOTH = 3'h2,
        M_IDLE_FAST = 3'h6
    } halt_mode_t;
endpackage

// ---- test/osc_model.sv ----
// Behavioural oscillators that toggle only while the block powers them.
module osc_model #(
    parameter int IRC_HALF  = 16,
    parameter int HXT_HALF  = 12,
    parameter int INTERNAL_SLOW_RC_OSC_HALF = 20,
    parameter int LXT_HALF  = 24
) (
    input  wire logic internal_fast_rc_run,
    input  wire logic fast_crystal_run,
    input  wire logic internal_slow_rc_run,
    input  wire logic slow_crystal_run,
    output logic      internal_fast_rc_osc,
    output logic      fast_crystal_osc,
    output logic      internal_slow_rc_osc,
    output logic      slow_crystal_osc
);
    timeunit 1ns;
    timeprecision 100ps;
    // A stopped oscillator falls low, so a dead source never yields edges.
    initial
        {internal_fast_rc_osc, fast_crystal_osc, internal_slow_rc_osc, slow_crystal_osc} = '0;
    initial
        forever #(IRC_HALF) internal_fast_rc_osc = internal_fast_rc_run & ~internal_fast_rc_osc;
    initial
        forever #(HXT_HALF) fast_crystal_osc = fast_crystal_run & ~fast_crystal_osc;
    initial
        forever #(INTERNAL_SLOW_RC_OSC_HALF) internal_slow_rc_osc = internal_slow_rc_run & ~internal_slow_rc_osc;
    initial
        forever #(LXT_HALF) slow_crystal_osc = slow_crystal_run & ~slow_crystal_osc;
endmodule

// ---- test/system_clock_mode_control_tb.sv ----
// Self-checking bench for the system clock mode control.
module system_clock_mode_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] sys_a = clock_mode_pkg::ADDR_SYS_SEL;
    localparam logic [11:0] irc_a = clock_mode_pkg::ADDR_IRC;
    localparam logic [11:0] hxt_a = clock_mode_pkg::ADDR_HXT;
    localparam logic [11:0] lxt_a = clock_mode_pkg::ADDR_LXT;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdata;
    logic        internal_fast_rc_osc, fast_crystal_osc, internal_slow_rc_osc, slow_crystal_osc;
    logic        internal_fast_rc_run, fast_crystal_run, internal_slow_rc_run, slow_crystal_run;
    logic        crystal_pin_in_func, crystal_pin_out_func, cpu_halt, sys_tick, switch_busy;
    logic        fast_crystal_drive_range, slow_crystal_speedup, rerr;
    logic [2:0]  halt_mode;
    logic [7:0]  d;
    int          mismatches = 0, checks_done = 0, gap;

    initial
        forever #2 pclk = ~pclk;

    system_clock_mode_control #(.IRC_EDGES(4), .HXT_EDGES(4), .LXT_EDGES(4)) dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .internal_fast_rc_osc, .fast_crystal_osc, .internal_slow_rc_osc, .slow_crystal_osc,
        .crystal_pin_in_func, .crystal_pin_out_func, .cpu_halt, .internal_fast_rc_run,
        .fast_crystal_run, .internal_slow_rc_run, .slow_crystal_run, .fast_crystal_drive_range,
        .slow_crystal_speedup, .sys_tick, .switch_busy, .halt_mode);

    osc_model osc_u (
        .internal_fast_rc_run, .fast_crystal_run, .internal_slow_rc_run, .slow_crystal_run,
        .internal_fast_rc_osc, .fast_crystal_osc, .internal_slow_rc_osc, .slow_crystal_osc);

    //--------------------------------------------------------------------
    // Shared tasks
    //--------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk("read data", rdata, {24'h0, exp});
    endtask

    // Outputs are sampled mid-cycle so no edge update can race the compare.
    task automatic pchk(input string what, ref logic s, input logic exp);
        @(negedge pclk);
        chk(what, s, exp);
        @(posedge pclk);
    endtask

    // Waits out a switch, then measures the spacing of two ticks.
    task automatic settle();
        @(negedge pclk);
        chk("switch busy", switch_busy, 1'b1);
        for (int i = 0; i < 5000 && switch_busy !== 1'b0; i++)
            @(negedge pclk);
        for (int i = 0; i < 3000 && sys_tick !== 1'b1; i++)
            @(negedge pclk);
        gap = 0;
        do
        begin
            @(negedge pclk);
            gap++;
        end
        while (sys_tick !== 1'b1 && gap < 3000);
        @(posedge pclk);
    endtask

    function automatic logic [2:0] mode_of(input int k);
        case (k)
            0: return clock_mode_pkg::M_SLEEP;
            1: return clock_mode_pkg::M_IDLE_SLOW;
            2: return clock_mode_pkg::M_IDLE_FAST;
            default: return clock_mode_pkg::M_IDLE_BOTH;
        endcase
    endfunction

    task automatic close_out();
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge pclk);
        mismatches++;
        close_out();
    end

    initial
    begin
        d = 8'($urandom(32'hb360));
        {crystal_pin_in_func, crystal_pin_out_func, cpu_halt} = 3'b110;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(sys_a, 8'h00);
        rdc(irc_a, 8'h01);
        rdc(hxt_a, 8'h00);
        rdc(lxt_a, 8'h00);
        apb(1'b0, 12'h010, 8'h00);
        chk("error flag", rerr, 1'b1);
        repeat (8)
        begin
            d = 8'($urandom);
            apb(1'b1, sys_a, d & 8'h17);
            rdc(sys_a, d & 8'h07);
        end
        apb(1'b1, irc_a, 8'h00);
        pchk("fast rc run", internal_fast_rc_run, 1'b0);
        rdc(irc_a, 8'h00);
        apb(1'b1, irc_a, 8'hff);
        rdc(irc_a, 8'h01);
        repeat (60) @(posedge pclk);
        rdc(irc_a, 8'h03);
        apb(1'b1, hxt_a, 8'h04);
        apb(1'b1, hxt_a, 8'h05);
        rdc(hxt_a, 8'h05);
        pchk("fast crystal run", fast_crystal_run, 1'b1);
        apb(1'b1, hxt_a, 8'h01);
        repeat (60) @(posedge pclk);
        rdc(hxt_a, 8'h07);
        crystal_pin_out_func <= 1'b0;
        apb(1'b1, hxt_a, 8'h01);
        pchk("drive range", fast_crystal_drive_range, 1'b0);
        crystal_pin_out_func <= 1'b1;
        apb(1'b1, lxt_a, 8'h05);
        repeat (80) @(posedge pclk);
        rdc(lxt_a, 8'h07);
        for (int f = 1; f >= 0; f--)
            for (int c = 0; c < 7; c++)
            begin
                apb(1'b1, sys_a, {3'(c), 1'b0, 1'(f), 3'b000});
                settle();
                chk("tick gap", 32'(gap), 32'((f ? 6 : 8) << c));
            end
        for (int s = 0; s < 2; s++)
        begin
            if (s == 1)
                apb(1'b1, lxt_a, 8'h04);
            apb(1'b1, sys_a, {5'h1c, 1'(s), 2'b00});
            if (s == 1)
            begin
                // The crystal restarts mid-handover, so the switch must wait for its flag.
                repeat (80) @(posedge pclk);
                rdc(lxt_a, 8'h04);
                apb(1'b1, lxt_a, 8'h05);
                repeat (24) @(posedge pclk);
                pchk("switch busy", switch_busy, 1'b1);
            end
            settle();
            chk("tick gap", 32'(gap), 32'(s ? 12 : 10));
        end
        apb(1'b1, lxt_a, 8'h01);
        pchk("speed-up", slow_crystal_speedup, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, sys_a, {6'h39, 2'(k)});
            cpu_halt <= 1'b1;
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk("halt mode", halt_mode, mode_of(k));
            chk("fast rc run", internal_fast_rc_run, k[1]);
            chk("slow crystal run", slow_crystal_run, k[0]);
            chk("slow rc run", internal_slow_rc_run, k[0]);
            chk("fast crystal run", fast_crystal_run, k[1]);
            @(posedge pclk);
            cpu_halt <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        apb(1'b1, sys_a, 8'h00);
        settle();
        chk("tick gap", 32'(gap), 32'd8);
        close_out();
    end
endmodule
